// ==== logic/rtc_pkg.sv ====
// Constants shared by the two-wire real-time clock slave port
package rtc_pkg;
    // ****************************************
    // Bus addressing
    // ****************************************
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    localparam int         REG_COUNT  = 8;
    localparam logic [2:0] IDX_SEC    = 3'h0;
    localparam logic [2:0] IDX_MIN    = 3'h1;
    localparam logic [2:0] IDX_HOUR   = 3'h2;
    localparam logic [2:0] IDX_DAY    = 3'h3;
    localparam logic [2:0] IDX_DATE   = 3'h4;
    localparam logic [2:0] IDX_MON    = 3'h5;
    localparam logic [2:0] IDX_YEAR   = 3'h6;
    localparam logic [2:0] IDX_CTRL   = 3'h7;
    // ****************************************
    // Fields, limits and reset values
    // ****************************************
    localparam int         STOP_BIT   = 7;
    localparam int         CENT_EN_BIT = 6;
    localparam int         CENT_BIT   = 7;
    localparam int         OUT_BIT    = 7;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] CAL_RESET  = 8'h00;
    localparam logic [7:0] ONE_RESET  = 8'h01;
    localparam logic [7:0] SEC_MAX    = 8'h59;
    localparam logic [7:0] HOUR_MAX   = 8'h23;
    localparam logic [7:0] DAY_MAX    = 8'h07;
    localparam logic [7:0] DATE_MAX   = 8'h31;
    localparam logic [7:0] MON_MAX    = 8'h12;
    localparam logic [7:0] YEAR_MAX   = 8'h99;
    // ****************************************
    // Timing
    // ****************************************
    localparam int         XTAL_HZ     = 32768;
    localparam int         CLK_HZ      = 50000000;
    localparam int         HOLD_MS     = 250;
    localparam int         HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;
    // ****************************************
    // Bus states
    // ****************************************
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_RX   = 7'h08,
        ST_RACK = 7'h10,
        ST_TX   = 7'h20,
        ST_TACK = 7'h40
    } bus_state_t;
endpackage

// ==== logic/rtc_two_wire_slave_port.sv ====
// Two-wire slave port with BCD calendar registers of a real-time clock
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Respond only to matching slave address
// - Eight registers, seconds through control, sequential
// - Calendar registers hold BCD values
// - Pointer advances after every acknowledged data byte
// - Time derived from 32.768 kHz crystal
// - SDA change with SCL high is control
// - SDA falling while SCL high is START
// - SDA rising while SCL high is STOP
// - One bit per pulse, sampled SCL high
// - START opens, STOP closes, unlimited bytes
// - Eight-bit bytes each followed by acknowledge
// - Acknowledge every byte when receiving
// - Acknowledge holds SDA low through high
// - No acknowledge: release SDA for STOP
// - First written byte loads the pointer
// - Read pointer advances only on acknowledge
// - Postpone clock update during reads, 250 ms
// - Output pin follows control bit D7
module rtc_two_wire_slave_port #(
    parameter int unsigned HOLD_CYCLES = rtc_pkg::HOLD_CYCLES,
    parameter int unsigned XTAL_DIV    = rtc_pkg::XTAL_HZ
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic sda_out,
    output var  logic sda_oe,
    input  wire logic crystal_input,
    output var  logic out_pin_out,
    output var  logic out_pin_oe
);
    // ****************************************
    // Reset release and pin synchronisers
    // ****************************************
    logic [1:0] rst_pipe;
    logic       rst_sync;
    logic       scl_meta, scl_s, scl_d;
    logic       sda_meta, sda_s, sda_d;
    logic       xtal_meta, xtal_s, xtal_d;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync = rst_pipe[1];

    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            scl_meta  <= 1'b1;
            scl_s     <= 1'b1;
            scl_d     <= 1'b1;
            sda_meta  <= 1'b1;
            sda_s     <= 1'b1;
            sda_d     <= 1'b1;
            xtal_meta <= 1'b0;
            xtal_s    <= 1'b0;
            xtal_d    <= 1'b0;
        end else begin
            scl_meta  <= scl_in;
            scl_s     <= scl_meta;
            scl_d     <= scl_s;
            sda_meta  <= sda_in;
            sda_s     <= sda_meta;
            sda_d     <= sda_s;
            xtal_meta <= crystal_input;
            xtal_s    <= xtal_meta;
            xtal_d    <= xtal_s;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

    // BCD increment with wrap, carry in bit 8
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] max,
                                          input logic [7:0] min);
        logic [8:0] r;
        if (v >= max) begin
            r = {1'b1, min};
        end else if (v[3:0] >= 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // ****************************************
    // Bus state machine
    // ****************************************
    rtc_pkg::bus_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift;
    logic [2:0] ptr, next_ptr;
    logic       first, next_first;
    logic       acked, next_acked;
    logic       next_sda_oe;
    logic       wr_en;
    logic [7:0] regs [rtc_pkg::REG_COUNT];

    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_shift  = shift;
        next_ptr    = ptr;
        next_first  = first;
        next_acked  = acked;
        next_sda_oe = sda_oe;
        wr_en       = 1'b0;
        if (stop_det) begin
            next_state  = rtc_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_det) begin
            next_state  = rtc_pkg::ST_ADDR;
            next_cnt    = 4'h0;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                rtc_pkg::ST_IDLE: begin
                end
                rtc_pkg::ST_ADDR, rtc_pkg::ST_RX: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda_s};
                        next_cnt   = cnt + 4'h1;
                    end else if (scl_fall && cnt == 4'h8) begin
                        if (state == rtc_pkg::ST_ADDR && shift[7:1] != rtc_pkg::SLAVE_ADDR) begin
                            next_state = rtc_pkg::ST_IDLE;
                        end else begin
                            next_sda_oe = 1'b1;
                            next_state  = (state == rtc_pkg::ST_ADDR) ? rtc_pkg::ST_AACK
                                                                      : rtc_pkg::ST_RACK;
                            if (state == rtc_pkg::ST_RX) begin
                                next_first = 1'b0;
                                if (first) begin
                                    next_ptr = shift[2:0];
                                end else begin
                                    wr_en    = 1'b1;
                                    next_ptr = ptr + 3'h1;
                                end
                            end
                        end
                    end
                end
                rtc_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (shift[0]) begin
                            next_state  = rtc_pkg::ST_TX;
                            next_shift  = regs[ptr];
                            next_sda_oe = ~regs[ptr][7];
                        end else begin
                            next_state  = rtc_pkg::ST_RX;
                            next_first  = 1'b1;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                rtc_pkg::ST_RACK: begin
                    if (scl_fall) begin
                        next_state  = rtc_pkg::ST_RX;
                        next_cnt    = 4'h0;
                        next_sda_oe = 1'b0;
                    end
                end
                rtc_pkg::ST_TX: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == 4'h8) begin
                            next_state  = rtc_pkg::ST_TACK;
                            next_sda_oe = 1'b0;
                        end else begin
                            next_shift  = {shift[6:0], 1'b0};
                            next_sda_oe = ~shift[6];
                        end
                    end
                end
                rtc_pkg::ST_TACK: begin
                    if (scl_rise) begin
                        next_acked = ~sda_s;
                        if (!sda_s) begin
                            next_ptr = ptr + 3'h1;
                        end
                    end else if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (acked) begin
                            next_state  = rtc_pkg::ST_TX;
                            next_shift  = regs[ptr];
                            next_sda_oe = ~regs[ptr][7];
                        end else begin
                            next_state  = rtc_pkg::ST_IDLE;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                default: begin
                    next_state  = rtc_pkg::ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state   <= rtc_pkg::ST_IDLE;
            cnt     <= 4'h0;
            shift   <= 8'h00;
            ptr     <= rtc_pkg::IDX_SEC;
            first   <= 1'b0;
            acked   <= 1'b0;
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            shift   <= next_shift;
            ptr     <= next_ptr;
            first   <= next_first;
            acked   <= next_acked;
            sda_oe  <= next_sda_oe;
            sda_out <= 1'b0;
        end
    end

    // ****************************************
    // Timekeeping and register file
    // ****************************************
    logic [15:0] div, next_div;
    logic [1:0]  pending, next_pending;
    logic [23:0] hold, next_hold;
    logic [7:0]  next_regs [rtc_pkg::REG_COUNT];
    logic        reading_clk, tick, apply, next_out_oe;

    assign reading_clk = (state == rtc_pkg::ST_TX || state == rtc_pkg::ST_TACK)
                         && ptr != rtc_pkg::IDX_CTRL;
    // one second per crystal period count
    assign tick  = xtal_s & ~xtal_d & ~regs[rtc_pkg::IDX_SEC][rtc_pkg::STOP_BIT]
                   && div == 16'(XTAL_DIV - 1);
    assign apply = pending != 2'h0 && !wr_en
                   && (!reading_clk || hold >= 24'(HOLD_CYCLES - 1));

    always_comb begin
        logic [8:0] r;
        r            = 9'h000;
        next_regs    = regs;
        next_div     = div;
        next_pending = pending;
        next_hold    = hold;
        if (xtal_s && !xtal_d) begin
            next_div = (div == 16'(XTAL_DIV - 1)) ? 16'h0000 : div + 16'h0001;
        end
        if (pending != 2'h0 && reading_clk && !apply) begin
            next_hold = hold + 24'h000001;
        end
        if (apply) begin
            next_hold = 24'h000000;
            r = bcd_inc({1'b0, regs[0][6:0]}, rtc_pkg::SEC_MAX, rtc_pkg::CAL_RESET);
            next_regs[0][6:0] = r[6:0];
            if (r[8]) begin
                r = bcd_inc({1'b0, regs[1][6:0]}, rtc_pkg::SEC_MAX, rtc_pkg::CAL_RESET);
                next_regs[1][6:0] = r[6:0];
            end
            if (r[8]) begin
                r = bcd_inc({2'h0, regs[2][5:0]}, rtc_pkg::HOUR_MAX, rtc_pkg::CAL_RESET);
                next_regs[2][5:0] = r[5:0];
            end
            if (r[8]) begin
                next_regs[3] = 8'(bcd_inc(regs[3], rtc_pkg::DAY_MAX, rtc_pkg::ONE_RESET));
                r = bcd_inc(regs[4], rtc_pkg::DATE_MAX, rtc_pkg::ONE_RESET);
                next_regs[4] = r[7:0];
            end
            if (r[8]) begin
                r = bcd_inc(regs[5], rtc_pkg::MON_MAX, rtc_pkg::ONE_RESET);
                next_regs[5] = r[7:0];
            end
            if (r[8]) begin
                r = bcd_inc(regs[6], rtc_pkg::YEAR_MAX, rtc_pkg::CAL_RESET);
                next_regs[6] = r[7:0];
            end
            if (r[8] && regs[2][rtc_pkg::CENT_EN_BIT]) begin
                next_regs[2][rtc_pkg::CENT_BIT] = ~regs[2][rtc_pkg::CENT_BIT];
            end
        end
        // Bus write wins; pending second kept
        if (wr_en) begin
            next_regs[ptr] = shift;
        end
        next_pending = pending - {1'b0, apply} + {1'b0, tick && (pending != 2'h3 || apply)};
        // pin low while control D7 is zero
        next_out_oe = ~next_regs[rtc_pkg::IDX_CTRL][rtc_pkg::OUT_BIT];
    end

    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            div         <= 16'h0000;
            pending     <= 2'h0;
            hold        <= 24'h000000;
            regs[0]     <= rtc_pkg::CAL_RESET;
            regs[1]     <= rtc_pkg::CAL_RESET;
            regs[2]     <= rtc_pkg::CAL_RESET;
            regs[3]     <= rtc_pkg::ONE_RESET;
            regs[4]     <= rtc_pkg::ONE_RESET;
            regs[5]     <= rtc_pkg::ONE_RESET;
            regs[6]     <= rtc_pkg::CAL_RESET;
            regs[7]     <= rtc_pkg::CTRL_RESET;
            out_pin_oe  <= 1'b0;
            out_pin_out <= 1'b0;
        end else begin
            div         <= next_div;
            pending     <= next_pending;
            hold        <= next_hold;
            regs        <= next_regs;
            out_pin_oe  <= next_out_oe;
            out_pin_out <= 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync);

    property p_start_addr;
        start_det && !stop_det |=> state == rtc_pkg::ST_ADDR && !sda_oe;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("START not taken");
    property p_stop_idle;
        stop_det |=> state == rtc_pkg::ST_IDLE ##1 !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("STOP not taken");
    property p_addr_miss;
        state == rtc_pkg::ST_ADDR && scl_fall && cnt == 4'h8 && !start_det && !stop_det
            && shift[7:1] != rtc_pkg::SLAVE_ADDR |=> state == rtc_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("Foreign address answered");
    property p_rx_ack;
        (state == rtc_pkg::ST_ADDR || state == rtc_pkg::ST_RX) && scl_fall && cnt == 4'h8
            && !start_det && !stop_det && (state == rtc_pkg::ST_RX
            || shift[7:1] == rtc_pkg::SLAVE_ADDR) |=> sda_oe;
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("Byte not acknowledged");
    property p_read_inc;
        state == rtc_pkg::ST_TACK && scl_rise && !sda_s && !start_det && !stop_det
            |=> ptr == $past(ptr) + 3'h1;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("Pointer not advanced");
    property p_nack_release;
        state == rtc_pkg::ST_TACK && scl_fall && !acked && !start_det
            |=> !sda_oe && state == rtc_pkg::ST_IDLE;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("Line held after NACK");
    property p_drive_low_only;
        $rose(sda_oe) |-> !scl_d;
    endproperty
    a_drive_low_only: assert property (p_drive_low_only) else $error("SDA moved with SCL high");
    property p_out_pin;
        wr_en && ptr == rtc_pkg::IDX_CTRL && !shift[rtc_pkg::OUT_BIT] |=> ##1 out_pin_oe;
    endproperty
    a_out_pin: assert property (p_out_pin) else $error("Output pin not driven low");
    property p_hold;
        apply && reading_clk |-> hold >= 24'(HOLD_CYCLES - 1);
    endproperty
    a_hold: assert property (p_hold) else $error("Update during clock read");
endmodule

`default_nettype wire

// ==== test/two_wire_master_model.sv ====
// Behavioural two-wire bus master that drives the slave port
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
    input  wire logic core_clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic pull
);
    // ****************************************
    // Bus phases
    // ****************************************
    initial begin
        scl  = 1'b1;
        pull = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // change data only while clock low
    task automatic bit_cycle(input logic drv, output logic smp);
        pull = drv;
        step(3);
        scl = 1'b1;
        step(4);
        smp = sda;
        scl = 1'b0;
        step(1);
    endtask
    task automatic start();
        pull = 1'b0;
        step(8);
        scl = 1'b1;
        step(4);
        pull = 1'b1;
        step(4);
        scl = 1'b0;
        step(1);
    endtask
    task automatic stop();
        pull = 1'b1;
        step(4);
        scl = 1'b1;
        step(4);
        pull = 1'b0;
        step(8);
    endtask
    task automatic xfer(input logic [7:0] wr, input logic rd, input logic mack,
                        output logic [7:0] got, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(rd ? 1'b0 : !wr[i], s);
            got[i] = s;
        end
        bit_cycle(rd & mack, s);
        ack = !s;
    endtask
endmodule
`default_nettype wire

// ==== test/test_rtc_two_wire_slave_port.sv ====
// Self-checking bench for the two-wire real-time clock slave port
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) \
    begin \
        total_checks++; \
        if ((a) !== (b)) begin \
            num_errors++; \
            $display("BAD %0t got %h expected %h", $time, a, b); \
        end \
    end
module test_rtc_two_wire_slave_port;
    localparam logic [7:0] WR_ADDR = {rtc_pkg::SLAVE_ADDR, 1'b0};
    logic       core_clk;
    logic       rst_n;
    logic       crystal_input;
    logic       xtal_run;
    logic       scl;
    logic       pull;
    logic       sda_out;
    logic       sda_oe;
    logic       out_pin_out;
    logic       out_pin_oe;
    wire logic  sda;
    int         num_errors;
    int         total_checks;
    logic       ack;
    logic [7:0] g;
    assign sda = !(sda_oe | pull);
    rtc_two_wire_slave_port #(
        .HOLD_CYCLES (200),
        .XTAL_DIV    (4)
    ) i_rtc_two_wire_slave_port (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .scl_in        (scl),
        .sda_in        (sda),
        .sda_out       (sda_out),
        .sda_oe        (sda_oe),
        .crystal_input (crystal_input),
        .out_pin_out   (out_pin_out),
        .out_pin_oe    (out_pin_oe)
    );
    two_wire_master_model i_two_wire_master_model (
        .core_clk (core_clk),
        .sda      (sda),
        .scl      (scl),
        .pull     (pull)
    );
    // ****************************************
    // Clocks and bus tasks
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        crystal_input = 1'b0;
        forever begin
            repeat (5) @(posedge core_clk);
            #1 crystal_input = xtal_run & !crystal_input;
        end
    end
    task automatic send(input logic [7:0] b);
        i_two_wire_master_model.xfer(b, 1'b0, 1'b0, g, ack);
        `CHECK(ack, 1'b1)
    endtask
    task automatic write_regs(input logic [7:0] ptr, input int n, input logic [7:0] d [8]);
        i_two_wire_master_model.start();
        send(WR_ADDR);
        send(ptr);
        for (int k = 0; k < n; k++) send(d[k]);
        i_two_wire_master_model.stop();
    endtask
    task automatic read_regs(input logic setp, input logic [7:0] ptr, input int n,
                             input logic [7:0] exp [8]);
        i_two_wire_master_model.start();
        if (setp) begin
            send(WR_ADDR);
            send(ptr);
            i_two_wire_master_model.start();
        end
        send(WR_ADDR | 8'h01);
        for (int k = 0; k < n; k++) begin
            i_two_wire_master_model.xfer(8'h00, 1'b1, k < n - 1, g, ack);
            `CHECK(g, exp[k])
        end
        repeat (20) @(posedge core_clk);
        #1;
        `CHECK(sda_oe, 1'b0)
        i_two_wire_master_model.stop();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset_values();
        read_regs(1'b1, 8'h00, 8, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80});
        `CHECK(out_pin_oe, 1'b0)
        `CHECK(out_pin_out, 1'b0)
        `CHECK(sda_out, 1'b0)
    endtask
    task automatic test_wrong_address();
        i_two_wire_master_model.start();
        i_two_wire_master_model.xfer(8'hA0, 1'b0, 1'b0, g, ack);
        `CHECK(ack, 1'b0)
        i_two_wire_master_model.xfer(WR_ADDR, 1'b0, 1'b0, g, ack);
        `CHECK(ack, 1'b0)
        i_two_wire_master_model.stop();
    endtask
    task automatic test_wrap_write();
        write_regs(8'h06, 3, '{8'h23, 8'h00, 8'h45, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        `CHECK(out_pin_oe, 1'b1)
        read_regs(1'b1, 8'h06, 3, '{8'h23, 8'h00, 8'h45, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        write_regs(8'h07, 1, '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        `CHECK(out_pin_oe, 1'b0)
    endtask
    task automatic test_nack_hold();
        write_regs(8'h01, 2, '{8'h37, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        write_regs(8'h01, 0, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        read_regs(1'b0, 8'h00, 1, '{8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        read_regs(1'b0, 8'h00, 1, '{8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        read_regs(1'b0, 8'h00, 2, '{8'h37, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    endtask
    task automatic test_timekeeping();
        write_regs(8'h00, 1, '{8'h58, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        xtal_run = 1'b1;
        repeat (8) @(posedge crystal_input);
        xtal_run = 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        read_regs(1'b1, 8'h00, 2, '{8'h00, 8'h38, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    endtask
    task automatic test_read_hold();
        logic [7:0] exp [5];
        exp = '{8'h00, 8'h38, 8'h12, 8'h01, 8'h01};
        write_regs(8'h00, 0, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        i_two_wire_master_model.start();
        send(WR_ADDR | 8'h01);
        xtal_run = 1'b1;
        fork
            begin
                repeat (4) @(posedge crystal_input);
                xtal_run = 1'b0;
            end
        join_none
        for (int k = 0; k < 5; k++) begin
            i_two_wire_master_model.xfer(8'h00, 1'b1, k < 4, g, ack);
            `CHECK(g, exp[k])
        end
        i_two_wire_master_model.stop();
        read_regs(1'b1, 8'h00, 1, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
    initial begin
        rst_n        = 1'b0;
        xtal_run     = 1'b0;
        num_errors   = 0;
        total_checks = 0;
        repeat (16) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        test_reset_values();
        test_wrong_address();
        test_wrap_write();
        test_nack_hold();
        test_timekeeping();
        test_read_hold();
        give_verdict();
    end
endmodule
`default_nettype wire
